// File: src/rtt_pkg.sv
/*
 Constants, opcodes and state types for the register-transfer, test and wait
 execution block. Assumes an 8-bit data path and a 16-bit index and stack.
*/
package rtt_pkg;
	// Opcodes of the group
	localparam logic [7:0] OP_ACC_TO_XL     = 8'h97;
	localparam logic [7:0] OP_CCR_TO_ACC    = 8'h85;
	localparam logic [7:0] OP_TST_DIR       = 8'h3D;
	localparam logic [7:0] OP_TST_ACC       = 8'h4D;
	localparam logic [7:0] OP_TST_XL        = 8'h5D;
	localparam logic [7:0] OP_TST_IX1       = 8'h6D;
	localparam logic [7:0] OP_TST_IX        = 8'h7D;
	localparam logic [7:0] OP_PREFIX        = 8'h9E;
	localparam logic [7:0] OP_SP_TO_HX      = 8'h95;
	localparam logic [7:0] OP_XL_TO_ACC     = 8'h9F;
	localparam logic [7:0] OP_HX_TO_SP      = 8'h94;
	localparam logic [7:0] OP_WAIT          = 8'h8F;
	// Cycle counts
	localparam logic [2:0] CYC_ONE          = 3'h1;
	localparam logic [2:0] CYC_TWO          = 3'h2;
	localparam logic [2:0] CYC_IX           = 3'h3;
	localparam logic [2:0] CYC_DIR          = 3'h4;
	localparam logic [2:0] CYC_SP1          = 3'h5;
	// Condition code bit positions
	localparam int CCR_V = 7;
	localparam int CCR_ONE6 = 6;
	localparam int CCR_ONE5 = 5;
	localparam int CCR_H = 4;
	localparam int CCR_I = 3;
	localparam int CCR_N = 2;
	localparam int CCR_Z = 1;
	localparam int CCR_C = 0;
	localparam logic [7:0] CCR_RESET        = 8'h68;
	localparam logic [15:0] ONE16           = 16'h0001;
	localparam logic [15:0] SP_RESET        = 16'h00FF;
	// Sequencer states
	typedef enum logic [3:0] {
		RTT_FETCH = 4'h1,
		RTT_EXEC  = 4'h2,
		RTT_WAIT  = 4'h4,
		RTT_PFX   = 4'h8
	} rtt_state_t;
	// Memory operand source
	typedef enum logic [1:0] {
		RTT_SRC_ACC = 2'h0,
		RTT_SRC_XL  = 2'h1,
		RTT_SRC_MEM = 2'h2
	} rtt_src_t;
endpackage

// File: src/rtt_opdec.sv
/*
 Opcode decoder: maps one opcode byte, with the prefix flag, to a legality
 bit, its cycle count and whether it reads a memory operand.
 Assumes the prefix byte has been recognised by the caller.
*/
module rtt_opdec
	import rtt_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [7:0] opcode,
	input  wire logic       prefixed,
	output logic            legal_reg,
	output logic [2:0]      cycles_reg,
	output logic            mem_reg
);
	logic       legal_next;
	logic [2:0] cycles_next;
	logic       mem_next;
	// Table lookup, registered so the caller sees it next cycle
	always_comb begin
		legal_next  = 1'b1;
		cycles_next = CYC_ONE;
		mem_next    = 1'b0;
		if (prefixed) begin
			legal_next  = (opcode == OP_TST_IX1);
			cycles_next = CYC_SP1;
			mem_next    = 1'b1;
		end else begin
			unique case (opcode)
				OP_TST_DIR, OP_TST_IX1: begin
					cycles_next = CYC_DIR;
					mem_next    = 1'b1;
				end
				OP_TST_IX: begin
					cycles_next = CYC_IX;
					mem_next    = 1'b1;
				end
				OP_SP_TO_HX, OP_HX_TO_SP, OP_WAIT: cycles_next = CYC_TWO;
				OP_ACC_TO_XL, OP_CCR_TO_ACC, OP_TST_ACC, OP_TST_XL, OP_XL_TO_ACC: cycles_next = CYC_ONE;
				default: legal_next = 1'b0;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			legal_reg  <= 1'b0;
			cycles_reg <= CYC_ONE;
			mem_reg    <= 1'b0;
		end else begin
			legal_reg  <= legal_next;
			cycles_reg <= cycles_next;
			mem_reg    <= mem_next;
		end
	end
endmodule // rtt_opdec

// File: src/rtt_core.sv
/*
 Execution block for transfers, sign/zero test and wait of an 8-bit CPU.
 Assumes opcodes arrive one per op_valid pulse while op_ready is high, and
 that memory operands are supplied on mem_data with the opcode.
*/
// Function
// - Accumulator copied to low index, one cycle
// - Condition codes copied to accumulator, one cycle
// - Condition byte bits six, five read one
// - Test changes only N, Z, clears V
// - N follows bit seven; V forced zero
// - Z set only when operand is zero
// - Register test forms take one cycle
// - Memory tests take 4,4,4,3 cycles; SP1 table 5 less one
// - Index pair gets stack pointer plus one
// - Low index copied to accumulator, one cycle
// - Stack pointer gets index pair minus one
// - Wait clears mask and gates core clock in the same cycle
// - Peripheral clocks keep running during wait
// - Reset, request pin or source wakes core
module rtt_core
	import rtt_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        op_valid,
	input  wire logic [7:0]  op_code,
	input  wire logic [7:0]  mem_data,
	input  wire logic        reset_pin_n,
	input  wire logic        irq_pin_n,
	input  wire logic        periph_irq,
	output logic             op_ready,
	output logic             op_illegal,
	output logic [7:0]       acc_out,
	output logic [15:0]      hx_out,
	output logic [15:0]      sp_out,
	output logic [7:0]       ccr_out,
	output logic             core_clk_en,
	output logic             periph_clk_en,
	output logic             int_take,
	output logic             wake_reset
);
	////////////////////////////////////////////////////////////////////////
	rtt_state_t  state_reg, state_next;
	logic [7:0]  acc_reg, acc_next;
	logic [15:0] hx_reg, hx_next;
	logic [15:0] sp_reg, sp_next;
	logic [7:0]  ccr_reg, ccr_next;
	logic [7:0]  opc_reg, opc_next;
	logic [7:0]  mdat_reg, mdat_next;
	logic        pfx_reg, pfx_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic        ill_reg, ill_next;
	logic        take_reg, take_next;
	logic        wrst_reg, wrst_next;
	logic        dec_legal;
	logic [2:0]  dec_cycles;
	logic        dec_mem;
	// Decoder samples the live byte, so its prefix view must be the live state too
	wire         pfx_phase = (state_reg == RTT_PFX);

	rtt_opdec u_dec (
		.clk        (clk),
		.rstn       (rstn),
		.opcode     (op_code),
		.prefixed   (pfx_phase),
		.legal_reg  (dec_legal),
		.cycles_reg (dec_cycles),
		.mem_reg    (dec_mem)
	);

	// Flag arithmetic shared by every test form
	function automatic logic [7:0] rtt_test_ccr(input logic [7:0] condition_code_reg, input logic [7:0] val);
		logic [7:0] r;
		r = condition_code_reg;
		r[CCR_V] = 1'b0;
		r[CCR_N] = val[7];
		r[CCR_Z] = (val == 8'h00);
		return r;                 // H, I, C kept
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Decode of the held opcode
	wire is_tax  = !pfx_reg && (opc_reg == OP_ACC_TO_XL);
	wire is_tpa  = !pfx_reg && (opc_reg == OP_CCR_TO_ACC);
	wire is_acc_sign_zero_check = !pfx_reg && (opc_reg == OP_TST_ACC);
	wire is_index_low_sign_zero_check = !pfx_reg && (opc_reg == OP_TST_XL);
	wire is_tstm = pfx_reg || (opc_reg == OP_TST_DIR) || (opc_reg == OP_TST_IX1) || (opc_reg == OP_TST_IX);
	wire is_tsx  = !pfx_reg && (opc_reg == OP_SP_TO_HX);
	wire is_txa  = !pfx_reg && (opc_reg == OP_XL_TO_ACC);
	wire is_txs  = !pfx_reg && (opc_reg == OP_HX_TO_SP);
	wire is_wait = !pfx_reg && (opc_reg == OP_WAIT);
	// Last execute cycle; state is committed only here
	wire last_cyc = (state_reg == RTT_EXEC) && (cnt_reg == CYC_ONE);
	// Wake sources; peripherals gate themselves with local enables
	wire wake_any = !reset_pin_n || !irq_pin_n || periph_irq;
	// Fixed ones forced at every byte view of the flags
	wire [7:0] ccr_view = ccr_reg | 8'h60;
	wire [15:0] hx_plus = sp_reg + ONE16;
	wire [15:0] sp_minus = hx_reg - ONE16;
	wire [7:0] tst_src = is_acc_sign_zero_check ? acc_reg : (is_index_low_sign_zero_check ? hx_reg[7:0] : mdat_reg);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		state_next = state_reg;
		opc_next   = opc_reg;
		mdat_next  = mdat_reg;
		pfx_next   = pfx_reg;
		cnt_next   = cnt_reg;
		ill_next   = 1'b0;
		take_next  = 1'b0;
		wrst_next  = 1'b0;
		unique case (state_reg)
			RTT_FETCH: begin
				pfx_next = 1'b0;
				// Pending request served between operations only
				if ((!irq_pin_n || periph_irq) && !ccr_reg[CCR_I]) begin
					take_next = 1'b1;
				end else if (op_valid) begin
					opc_next  = op_code;
					mdat_next = mem_data; // Operand only read
					if (op_code == OP_PREFIX) begin
						state_next = RTT_PFX;
					end else begin
						state_next = RTT_EXEC;
						cnt_next   = 3'h0;
					end
				end
			end
			RTT_PFX: begin
				if (op_valid) begin
					opc_next   = op_code;
					mdat_next  = mem_data;
					pfx_next   = 1'b1;
					state_next = RTT_EXEC;
					cnt_next   = 3'h0;
				end
			end
			RTT_EXEC: begin
				// Zero means decoder result not yet loaded
				if (cnt_reg == 3'h0) begin
					if (!dec_legal) begin
						ill_next   = 1'b1;
						state_next = RTT_FETCH;
					end else begin
						cnt_next = pfx_reg ? (dec_cycles - 3'h1) : dec_cycles;
						if (dec_cycles == CYC_ONE) begin
							cnt_next = CYC_ONE;
						end
					end
				end else if (cnt_reg == CYC_ONE) begin
					state_next = is_wait ? RTT_WAIT : RTT_FETCH;
				end else begin
					cnt_next = cnt_reg - 3'h1;
				end
			end
			RTT_WAIT: begin
				if (wake_any) begin
					state_next = RTT_FETCH;
					wrst_next  = !reset_pin_n;
				end
			end
			default: state_next = RTT_FETCH;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Architectural updates on the last execute cycle
	always_comb begin
		acc_next = acc_reg;
		hx_next  = hx_reg;
		sp_next  = sp_reg;
		ccr_next = ccr_reg;
		if (last_cyc) begin
			if (is_tax) hx_next[7:0] = acc_reg;
			if (is_tpa) acc_next = ccr_view;
			if (is_txa) acc_next = hx_reg[7:0];
			if (is_acc_sign_zero_check || is_index_low_sign_zero_check || is_tstm) ccr_next = rtt_test_ccr(ccr_reg, tst_src);
			if (is_tsx) hx_next = hx_plus;
			if (is_txs) sp_next = sp_minus;
			if (is_wait) ccr_next[CCR_I] = 1'b0;
		end
	end

	// Short register process: everything computed above
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= RTT_FETCH;
			acc_reg   <= 8'h00;
			hx_reg    <= 16'h0000;
			sp_reg    <= SP_RESET;
			ccr_reg   <= CCR_RESET;
			opc_reg   <= 8'h00;
			mdat_reg  <= 8'h00;
			pfx_reg   <= 1'b0;
			cnt_reg   <= 3'h0;
			ill_reg   <= 1'b0;
			take_reg  <= 1'b0;
			wrst_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			acc_reg   <= acc_next;
			hx_reg    <= hx_next;
			sp_reg    <= sp_next;
			ccr_reg   <= ccr_next | 8'h60;
			opc_reg   <= opc_next;
			mdat_reg  <= mdat_next;
			pfx_reg   <= pfx_next;
			cnt_reg   <= cnt_next;
			ill_reg   <= ill_next;
			take_reg  <= take_next;
			wrst_reg  <= wrst_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs; clock gates are plain enables for a gating cell
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_ready      <= 1'b0;
			op_illegal    <= 1'b0;
			acc_out       <= 8'h00;
			hx_out        <= 16'h0000;
			sp_out        <= SP_RESET;
			ccr_out       <= CCR_RESET;
			core_clk_en   <= 1'b1;
			periph_clk_en <= 1'b1;
			int_take      <= 1'b0;
			wake_reset    <= 1'b0;
		end else begin
			op_ready      <= (state_next == RTT_FETCH) || (state_next == RTT_PFX);
			op_illegal    <= ill_next;
			acc_out       <= acc_next;
			hx_out        <= hx_next;
			sp_out        <= sp_next;
			ccr_out       <= ccr_next | 8'h60;
			core_clk_en   <= (state_next != RTT_WAIT);
			periph_clk_en <= 1'b1;
			int_take      <= take_next;
			wake_reset    <= wrst_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence seq_wait_end;
		last_cyc && is_wait;
	endsequence
	sequence seq_in_wait;
		state_reg == RTT_WAIT;
	endsequence

	AST_CCR_ONES: assert property (@(posedge clk) disable iff (!rstn) ccr_out[6:5] == 2'b11)
		else $error("condition byte fixed ones lost");
	AST_TAX: assert property (@(posedge clk) disable iff (!rstn)
		last_cyc && is_tax |=> hx_reg[7:0] == $past(acc_reg) && acc_reg == $past(acc_reg) && ccr_reg == $past(ccr_reg))
		else $error("acc to index low copy wrong");
	AST_TPA: assert property (@(posedge clk) disable iff (!rstn)
		last_cyc && is_tpa |=> acc_reg == ($past(ccr_reg) | 8'h60) && $stable(ccr_reg))
		else $error("status to acc copy wrong");
	AST_TXA: assert property (@(posedge clk) disable iff (!rstn)
		last_cyc && is_txa |=> acc_reg == $past(hx_reg[7:0]) && $stable(hx_reg))
		else $error("index low to acc copy wrong");
	AST_TEST: assert property (@(posedge clk) disable iff (!rstn)
		last_cyc && (is_acc_sign_zero_check || is_index_low_sign_zero_check || is_tstm) |=> !ccr_reg[CCR_V] && ccr_reg[CCR_N] == $past(tst_src[7])
		&& ccr_reg[CCR_Z] == ($past(tst_src) == 8'h00) && ccr_reg[CCR_C] == $past(ccr_reg[CCR_C])
		&& ccr_reg[CCR_I] == $past(ccr_reg[CCR_I]) && ccr_reg[CCR_H] == $past(ccr_reg[CCR_H]))
		else $error("test flags wrong");
	AST_ONE_CYC: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == RTT_EXEC && cnt_reg == 3'h0 && dec_legal && dec_cycles == CYC_ONE |=> last_cyc)
		else $error("single cycle op not finishing");
	AST_IX_CYC: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == RTT_EXEC && cnt_reg == 3'h0 && !pfx_reg && opc_reg == OP_TST_IX |=> !last_cyc ##1 !last_cyc ##1 last_cyc)
		else $error("indexed test cycle count wrong");
	AST_TSX: assert property (@(posedge clk) disable iff (!rstn)
		last_cyc && is_tsx |=> hx_reg == $past(sp_reg) + ONE16 && $stable(sp_reg))
		else $error("stack to index pair wrong");
	AST_TXS: assert property (@(posedge clk) disable iff (!rstn)
		last_cyc && is_txs |=> sp_reg == $past(hx_reg) - ONE16 && $stable(hx_reg))
		else $error("index pair to stack wrong");
	AST_WAIT: assert property (@(posedge clk) disable iff (!rstn)
		seq_wait_end |=> seq_in_wait ##0 (!ccr_reg[CCR_I] && !core_clk_en))
		else $error("wait did not clear mask and gate clock");
	AST_MEM_DEC: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == RTT_EXEC && cnt_reg == 3'h0 && dec_legal |-> dec_mem == is_tstm)
		else $error("memory operand decode disagrees with held opcode");
	AST_PERIPH: assert property (@(posedge clk) disable iff (!rstn) seq_in_wait |-> periph_clk_en)
		else $error("peripheral clock stopped in wait");
	AST_WAKE: assert property (@(posedge clk) disable iff (!rstn)
		(seq_in_wait and wake_any) |=> state_reg == RTT_FETCH ##1 core_clk_en)
		else $error("no wake from wait");
	AST_BOUNDARY: assert property (@(posedge clk) disable iff (!rstn)
		int_take |-> $past(state_reg) == RTT_FETCH)
		else $error("interrupt taken mid operation");
endmodule // rtt_core

// File: tb/rtt_prog_model.sv
/*
 Program memory and wake sources facing rtt_core: hands one opcode byte
 with its operand per request and pulls a wake line on command.
 Assumes one clock, requests launched 2 ns after a rising edge.
*/
module rtt_prog_model (
	input  wire logic       clk,
	input  wire logic       op_ready,
	input  wire logic       core_clk_en,
	output logic            op_valid,
	output logic [7:0]      op_code,
	output logic [7:0]      mem_data,
	output logic            reset_pin_n,
	output logic            irq_pin_n,
	output logic            periph_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		op_valid = 1'b0;
		op_code = 8'h00;
		mem_data = 8'h00;
		reset_pin_n = 1'b1;
		irq_pin_n = 1'b1;
		periph_irq = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Byte held until an edge samples op_ready high; lat counts edges to ready
	task automatic fetch(input logic [7:0] code, input logic [7:0] data, output int lat);
		int n;
		@(posedge clk);
		#2;
		op_valid = 1'b1;
		op_code = code;
		mem_data = data;
		n = 0;
		while (op_ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		#2;
		op_valid = 1'b0;
		op_code = ~code; // Released bus must not show a stale byte
		mem_data = ~data;
		lat = 0;
		do begin
			@(negedge clk);
			lat++;
		end while (op_ready !== 1'b1 && lat < 20);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Wake line held until the core clock returns, then a few cycles more
	task automatic wake(input int kind);
		int n;
		@(posedge clk);
		#2;
		if (kind == 0) periph_irq = 1'b1; // Already gated by its local enable
		else if (kind == 1) irq_pin_n = 1'b0;
		else reset_pin_n = 1'b0;
		n = 0;
		while (core_clk_en !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
		#2;
		periph_irq = 1'b0;
		irq_pin_n = 1'b1;
		reset_pin_n = 1'b1;
	endtask
endmodule // rtt_prog_model

// File: tb/test_rtt_core.sv
/*
 Self-checking bench of rtt_core: corner and random opcodes, refusals,
 wait with each wake source. Assumes rtt_prog_model drives the bus.
*/
module test_rtt_core;
	import rtt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        op_valid, reset_pin_n, irq_pin_n, periph_irq;
	logic [7:0]  op_code, mem_data, acc_out, ccr_out, m_acc, m_ccr;
	logic        op_ready, op_illegal, core_clk_en, periph_clk_en, int_take, wake_reset;
	logic [15:0] hx_out, sp_out, m_hx, m_sp;
	int          err_count = 0, checks_done = 0, cyc = 0;
	int          ill_cnt = 0, int_cnt = 0, wr_cnt = 0, seed, lat, base;
	logic [7:0]  ops [11] = '{8'h97, 8'h85, 8'h4D, 8'h5D, 8'h3D, 8'h6D, 8'h7D, 8'h9F, 8'h95, 8'h94, 8'h9E};
	always #12.5 clk = ~clk;
	rtt_core dut_u (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code), .mem_data(mem_data),
		.reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n), .periph_irq(periph_irq), .op_ready(op_ready),
		.op_illegal(op_illegal), .acc_out(acc_out), .hx_out(hx_out), .sp_out(sp_out), .ccr_out(ccr_out),
		.core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .int_take(int_take),
		.wake_reset(wake_reset));
	rtt_prog_model mem_u (.clk(clk), .op_ready(op_ready), .core_clk_en(core_clk_en), .op_valid(op_valid),
		.op_code(op_code), .mem_data(mem_data), .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n),
		.periph_irq(periph_irq));
	////////////////////////////////////////////////////////////////////////////////
	// Pulse counters and hang guard
	always @(posedge clk) begin
		cyc++;
		if (op_illegal === 1'b1) ill_cnt++;
		if (int_take === 1'b1) int_cnt++;
		if (wake_reset === 1'b1) wr_cnt++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("Mismatches %0d, checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Expected state after one operation
	function automatic void predict(input logic [7:0] op, input logic [7:0] d);
		logic [7:0] v;
		v = (op == OP_TST_ACC) ? m_acc : (op == OP_TST_XL) ? m_hx[7:0] : d;
		case (op)
			8'h97: m_hx[7:0] = m_acc;
			8'h85: m_acc = m_ccr;
			8'h9F: m_acc = m_hx[7:0];
			8'h95: m_hx = m_sp + 16'h0001;
			8'h94: m_sp = m_hx - 16'h0001;
			default: begin
				m_ccr[7] = 1'b0;
				m_ccr[2] = v[7];
				m_ccr[1] = (v == 8'h00);
			end
		endcase
	endfunction
	// Cycle count of each unprefixed opcode in ops
	function automatic int cyc_of(input logic [7:0] op);
		case (op)
			8'h95, 8'h94: return 2;
			8'h7D: return 3;
			8'h3D, 8'h6D: return 4;
			default: return 1;
		endcase
	endfunction
	task automatic check_state();
		check({8'h00, acc_out}, {8'h00, m_acc});
		check(hx_out, m_hx);
		check(sp_out, m_sp);
		check({8'h00, ccr_out}, {8'h00, m_ccr});
		check({14'h0000, ccr_out[6:5]}, 16'h0003);
	endtask
	// Reset, also used mid-run between wait scenarios
	task automatic do_reset();
		@(posedge clk);
		#2;
		rstn = 1'b0;
		repeat (6) @(posedge clk);
		#2;
		rstn = 1'b1;
		m_acc = 8'h00;
		m_hx = 16'h0000;
		m_sp = 16'h00FF;
		m_ccr = 8'h68;
		check_state();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// One legal operation; latency measured against the one-cycle baseline
	task automatic run_op(input logic [7:0] op, input logic [7:0] d);
		int n;
		n = ill_cnt;
		if (op == OP_PREFIX) mem_u.fetch(OP_PREFIX, 8'h00, lat);
		mem_u.fetch((op == OP_PREFIX) ? OP_TST_IX1 : op, d, lat);
		check(lat, base + ((op == OP_PREFIX) ? 5 - 2 : cyc_of(op) - 1));
		predict((op == OP_PREFIX) ? OP_TST_IX1 : op, d);
		repeat (2) @(negedge clk);
		check(ill_cnt - n, 0);
		check_state();
	endtask
	// Refused byte leaves every register as it was
	task automatic run_bad(input logic [7:0] first, input logic [7:0] op);
		int n;
		n = ill_cnt;
		if (first == OP_PREFIX) mem_u.fetch(OP_PREFIX, 8'h00, lat);
		mem_u.fetch(op, 8'h00, lat);
		repeat (2) @(negedge clk);
		check(ill_cnt - n, 1);
		check_state();
	endtask
	// Wait, then wake from source kind: 0 peripheral, 1 request pin, 2 reset pin
	task automatic run_wait(input int kind);
		int ni;
		int nw;
		ni = int_cnt;
		nw = wr_cnt;
		mem_u.fetch(OP_WAIT, 8'h00, lat);
		m_ccr[3] = 1'b0;
		check(core_clk_en, 1'b0);
		check(periph_clk_en, 1'b1);
		check_state();
		check(op_ready, 1'b0);
		mem_u.wake(kind);
		check(core_clk_en, 1'b1);
		check(int_cnt > ni, kind != 2);
		check(wr_cnt > nw, kind == 2);
		do_reset();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: corners, random mix, refusals, waits
	initial begin
		seed = 32'hc518;
		do_reset();
		mem_u.fetch(OP_ACC_TO_XL, 8'h00, base); // Baseline; no state change from reset
		repeat (2) @(negedge clk);
		foreach (ops[i]) run_op(ops[i], 8'h00);
		foreach (ops[i]) run_op(ops[i], 8'h80);
		repeat (60) run_op(ops[$unsigned($random(seed)) % 11], 8'($random(seed)));
		run_bad(8'h00, 8'h00);
		run_bad(OP_PREFIX, OP_TST_ACC);
		for (int k = 0; k < 3; k++) run_wait(k);
		give_verdict();
	end
endmodule // test_rtt_core
